// File: hw/rtcw_pkg.sv
/*
  Constants for the clock SRAM write and update control block:
  address map of the clock bytes, control bits, BCD limits and timing.
  Assumes a 100 MHz core clock and a 17-bit byte-addressed memory.
*/
`default_nettype none

package rtcw_pkg;

  // ---------------------------------------------------------------
  // Widths and memory size
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 17;
  localparam int DATA_W    = 8;
  localparam int RAM_DEPTH = 131072;
  localparam int PIN_W     = ADDR_W + DATA_W + 3;
  localparam int TMR_W     = 32;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 17'h1fff8;
  localparam logic [ADDR_W-1:0] ADDR_SEC    = 17'h1fff9;
  localparam logic [ADDR_W-1:0] ADDR_YEAR   = 17'h1ffff;
  localparam logic [ADDR_W-1:0] ADDR_CENT   = 17'h1fff1;

  // Control register bits
  localparam int BIT_WRITE = 7;
  localparam int BIT_READ  = 6;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

  // Clock byte slots inside the time vector
  localparam int T_SEC   = 0;
  localparam int T_MIN   = 1;
  localparam int T_HOUR  = 2;
  localparam int T_DAY   = 3;
  localparam int T_DATE  = 4;
  localparam int T_MONTH = 5;
  localparam int T_YEAR  = 6;
  localparam int T_CENT  = 7;
  localparam int T_NUM   = 8;

  // ---------------------------------------------------------------
  // BCD limits and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BCD_ZERO  = 8'h00;
  localparam logic [7:0] BCD_ONE   = 8'h01;
  localparam logic [7:0] BCD_59    = 8'h59;
  localparam logic [7:0] BCD_23    = 8'h23;
  localparam logic [7:0] BCD_DAYS  = 8'h07;
  localparam logic [7:0] BCD_DEC   = 8'h12;
  localparam logic [7:0] BCD_99    = 8'h99;
  localparam logic [7:0] BCD_FEB   = 8'h02;
  localparam logic [7:0] BCD_APR   = 8'h04;
  localparam logic [7:0] BCD_JUN   = 8'h06;
  localparam logic [7:0] BCD_SEP   = 8'h09;
  localparam logic [7:0] BCD_NOV   = 8'h11;
  localparam logic [7:0] BCD_D28   = 8'h28;
  localparam logic [7:0] BCD_D29   = 8'h29;
  localparam logic [7:0] BCD_D30   = 8'h30;
  localparam logic [7:0] BCD_D31   = 8'h31;
  localparam logic [3:0] DIGIT_9   = 4'h9;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SECOND_NS      = 1000000000;
  localparam int SEC_CYCLES     = SECOND_NS / CLK_PERIOD_NS;
  localparam int REC_TIME_NS    = 200000000;
  localparam int REC_CYCLES     = REC_TIME_NS / CLK_PERIOD_NS;

endpackage : rtcw_pkg

`default_nettype wire

// File: hw/rtcw_ctrl.sv
/*
  Parallel SRAM port of a battery-backed clock memory with the logic that
  refreshes the visible clock bytes from running BCD counters.
  Assumes asynchronous host pins sampled on core_clk_i and a digital
  power-fail level from an external detector.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// R01 - Write begins when both chip select and write strobe are low
// R02 - Write ends at first rising select or strobe; data taken then
// R03 - Host holds address stable through the whole write
// R04 - Host should keep output enable high during writes
// R05 - Falling write strobe releases already driven data lines
// R06 - Select and strobe falling together never drive data lines
// R07 - Power fail deselects, blocks writes, floats outputs, ignores inputs
// R08 - Power fail mid-write may lose only the addressed byte
// R09 - Nine clock and control bytes live inside the memory map
// R10 - Visible clock copies refreshed together from incremented counters
// R11 - Clock registers hold BCD, one digit per nibble
// R12 - Read-hold bit six stops refreshes while it is one
// R13 - Internal counters keep counting while refreshes are halted
// R14 - Frozen copies show the time current when halt was requested
// R15 - A halt lets a refresh in progress complete first
// R16 - After read-hold clears, next refresh comes one second later
// R17 - Set-time bit seven halts refreshes like read-hold
// R18 - Clearing set-time loads visible time bytes into counters
// R19 - After set-time clears, next refresh comes one second later
// R20 - Power return clears set-time and read-hold bits
// R21 - Software should halt refreshes before reading the time
// R22 - Software loads time in 24-hour BCD while set-time is one
// R23 - Seventeen address bits select one of 131072 bytes
// R24 - Data lines driven only when select and output enable low
// R25 - Deselect held for a recovery interval after power returns
// R26 - Power fail is one synchronised digital input

module rtcw_ctrl
  import rtcw_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES,
  parameter int REC_CYCLES_P = REC_CYCLES
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // Host bus
  input  wire logic [ADDR_W-1:0] address_lines_i,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   data_lines_oe_o,
  input  wire logic              chip_sel_n_i,
  input  wire logic              out_en_n_i,
  input  wire logic              write_n_i,
  // Power monitor
  input  wire logic              power_fail_i,
  output logic                   deselected_o
);

  localparam logic [TMR_W-1:0] SEC_LAST = TMR_W'(SEC_CYCLES_P - 1);
  localparam logic [TMR_W-1:0] REC_LAST = TMR_W'(REC_CYCLES_P - 1);
  typedef logic [T_NUM-1:0][7:0] rtcw_time_t;
  localparam rtcw_time_t TIME_RESET = {BCD_ZERO, BCD_ZERO, BCD_ONE, BCD_ONE,
                                       BCD_ONE, BCD_ZERO, BCD_ZERO, BCD_ZERO};

  typedef struct packed {
    logic [PIN_W-1:0]  pin1;
    logic [PIN_W-1:0]  pin2;
    logic [PIN_W-1:0]  pin3;
    logic [PIN_W-1:0]  pin_q;
    logic              pf1;
    logic              pf2;
    logic              pf3;
    logic              pf_q;
    logic              recovering;
    logic [TMR_W-1:0]  rec_cnt;
    logic              wr_act;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [TMR_W-1:0]  tmr;
    logic [DATA_W-1:0] ctrl;
    rtcw_time_t        vis;
    rtcw_time_t        cnt;
    logic [DATA_W-1:0] dout;
    logic              doe;
  } rtcw_state_s;

  rtcw_state_s st_r;
  rtcw_state_s st_nxt;
  logic [DATA_W-1:0] ram [RAM_DEPTH];
  logic              ram_we;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == DIGIT_9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc
  // Slot of a clock byte; bit 3 flags a hit
  function automatic logic [3:0] time_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = ADDR_W'(a - ADDR_SEC);
    if (a == ADDR_CENT) begin
      return {1'b1, 3'(T_CENT)};
    end
    if (a >= ADDR_SEC && a <= ADDR_YEAR) begin
      return {1'b1, off[2:0]};
    end
    return 4'h0;
  endfunction : time_slot
  function automatic logic [7:0] month_len(input logic [7:0] m,
                                            input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == BCD_FEB) begin
      return leap ? BCD_D29 : BCD_D28;
    end
    if (m == BCD_APR || m == BCD_JUN || m == BCD_SEP || m == BCD_NOV) begin
      return BCD_D30;
    end
    return BCD_D31;
  endfunction : month_len

  // One second of BCD time with calendar carries
  function automatic rtcw_time_t advance(input rtcw_time_t c);
    rtcw_time_t t;
    t = c;
    t[T_SEC] = bcd_inc(c[T_SEC]);
    if (c[T_SEC] == BCD_59) begin
      t[T_SEC] = BCD_ZERO;
      t[T_MIN] = bcd_inc(c[T_MIN]);
      if (c[T_MIN] == BCD_59) begin
        t[T_MIN]  = BCD_ZERO;
        t[T_HOUR] = bcd_inc(c[T_HOUR]);
        if (c[T_HOUR] == BCD_23) begin
          t[T_HOUR] = BCD_ZERO;
          t[T_DAY]  = (c[T_DAY] == BCD_DAYS) ? BCD_ONE : bcd_inc(c[T_DAY]);
          t[T_DATE] = bcd_inc(c[T_DATE]);
          if (c[T_DATE] == month_len(c[T_MONTH], c[T_YEAR])) begin
            t[T_DATE]  = BCD_ONE;
            t[T_MONTH] = bcd_inc(c[T_MONTH]);
            if (c[T_MONTH] == BCD_DEC) begin
              t[T_MONTH] = BCD_ONE;
              t[T_YEAR]  = bcd_inc(c[T_YEAR]);
              if (c[T_YEAR] == BCD_99) begin
                t[T_YEAR] = BCD_ZERO;
                t[T_CENT] = (c[T_CENT] == BCD_99) ? BCD_ZERO
                                                  : bcd_inc(c[T_CENT]);
              end
            end
          end
        end
      end
    end
    return t;
  endfunction : advance

  // ---------------------------------------------------------------
  // Qualified pins: {cs_n, oe_n, we_n, addr, data}
  // ---------------------------------------------------------------
  logic              cs_n_q;
  logic              oe_n_q;
  logic              we_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] din_q;
  logic              bus_ok;
  logic              wr_now;
  logic              wr_end;
  logic              tick;
  logic              halt;
  logic [3:0]        slot;
  logic [DATA_W-1:0] new_ctrl;

  assign {cs_n_q, oe_n_q, we_n_q, addr_q, din_q} = st_r.pin_q;
  assign bus_ok = !st_r.pf_q && !st_r.recovering;                  // R07
  assign wr_now = bus_ok && !cs_n_q && !we_n_q;                    // R01
  assign wr_end = st_r.wr_act && !wr_now && bus_ok;                // R02 R08
  assign tick   = st_r.tmr == SEC_LAST;
  assign halt   = st_r.ctrl[BIT_WRITE] || st_r.ctrl[BIT_READ];     // R12 R17
  assign slot   = time_slot(st_r.wr_addr);                         // R23
  assign new_ctrl = (wr_end && st_r.wr_addr == ADDR_CTRL) ? st_r.wr_data
                                                          : st_r.ctrl;
  assign ram_we = wr_end && !slot[3] && st_r.wr_addr != ADDR_CTRL;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Three-stage sampling, accepted once stages two and three agree
    st_nxt.pin1 = {chip_sel_n_i, out_en_n_i, write_n_i,
                   address_lines_i, data_lines_i};
    st_nxt.pin2 = st_r.pin1;
    st_nxt.pin3 = st_r.pin2;
    if (st_r.pin2 == st_r.pin3) begin
      st_nxt.pin_q = st_r.pin3;
    end
    st_nxt.pf1 = power_fail_i;
    st_nxt.pf2 = st_r.pf1;
    st_nxt.pf3 = st_r.pf2;
    if (st_r.pf2 == st_r.pf3) begin
      st_nxt.pf_q = st_r.pf3;                                      // R26
    end

    // Recovery deselect after power returns
    if (st_r.pf_q) begin
      st_nxt.recovering = 1'b1;                                    // R25
      st_nxt.rec_cnt    = '0;
    end else if (st_r.recovering) begin
      st_nxt.rec_cnt = TMR_W'(st_r.rec_cnt + 1'b1);
      if (st_r.rec_cnt == REC_LAST) begin
        st_nxt.recovering = 1'b0;                                  // R25
      end
    end

    // Write framing: latest address and data kept until termination
    st_nxt.wr_act = wr_now;
    if (wr_now) begin
      st_nxt.wr_addr = addr_q;
      st_nxt.wr_data = din_q;
    end
    // Second timer and counters run regardless of halt
    st_nxt.tmr = tick ? '0 : TMR_W'(st_r.tmr + 1'b1);
    if (tick) begin
      st_nxt.cnt = advance(st_r.cnt);                              // R13 R11
      if (!halt) begin                                             // R14
        st_nxt.vis = advance(st_r.cnt);                            // R10 R15
      end
    end
    // Host writes to the clock bytes and control register
    if (wr_end && slot[3]) begin
      st_nxt.vis[slot[2:0]] = st_r.wr_data;                        // R09
    end
    if (wr_end && st_r.wr_addr == ADDR_CTRL) begin
      st_nxt.ctrl = st_r.wr_data;                                  // R12 R17
      if (st_r.ctrl[BIT_READ] && !new_ctrl[BIT_READ]) begin
        st_nxt.tmr = '0;                                           // R16
      end
      if (st_r.ctrl[BIT_WRITE] && !new_ctrl[BIT_WRITE]) begin
        st_nxt.cnt = st_r.vis;                                     // R18
        st_nxt.tmr = '0;                                           // R19
      end
    end

    if (st_r.pf_q) begin
      st_nxt.ctrl[BIT_WRITE] = 1'b0;                               // R20
      st_nxt.ctrl[BIT_READ]  = 1'b0;                               // R20
    end
    // Read path: drive only for select and output enable with no write
    st_nxt.doe = bus_ok && !cs_n_q && !oe_n_q && we_n_q;           // R24 R05 R06
    if (addr_q == ADDR_CTRL) begin
      st_nxt.dout = st_r.ctrl;
    end else if (time_slot(addr_q) != 4'h0) begin
      st_nxt.dout = st_r.vis[3'(time_slot(addr_q))];
    end else begin
      st_nxt.dout = ram[addr_q];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r       <= '0;
      st_r.pin1  <= '1;
      st_r.pin2  <= '1;
      st_r.pin3  <= '1;
      st_r.pin_q <= '1;
      st_r.ctrl  <= CTRL_RESET;
      st_r.cnt   <= TIME_RESET;
      st_r.vis   <= TIME_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Memory array; a write cut by power fail is never committed
  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      ram[st_r.wr_addr] <= st_r.wr_data;                           // R08
    end
  end

  assign data_lines_o    = st_r.dout;
  assign data_lines_oe_o = st_r.doe;
  assign deselected_o    = st_r.recovering;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_ctrl_write_end;
    (st_r.wr_act && st_r.wr_addr == ADDR_CTRL && bus_ok && !wr_now);
  endsequence

  property p_write_start;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.wr_act |-> $past(!cs_n_q && !we_n_q);
  endproperty
  a_write_start: assert property (p_write_start)                   // R01
    else $error("write active without select and strobe low");
  property p_ctrl_commit;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      s_ctrl_write_end |=> (st_r.ctrl[5:0] == $past(st_r.wr_data[5:0]));
  endproperty
  a_ctrl_commit: assert property (p_ctrl_commit)                   // R02
    else $error("control byte not taken at write end");
  property p_no_drive_in_write;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.wr_act |-> !data_lines_oe_o;
  endproperty
  a_no_drive_in_write: assert property (p_no_drive_in_write)       // R06
    else $error("data lines driven during a write");
  property p_float_on_strobe;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (!we_n_q) |=> !data_lines_oe_o;
  endproperty
  a_float_on_strobe: assert property (p_float_on_strobe)           // R05
    else $error("data lines driven while strobe low");
  property p_drive_needs_enables;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      data_lines_oe_o |-> $past(!cs_n_q && !oe_n_q && we_n_q);
  endproperty
  a_drive_needs_enables: assert property (p_drive_needs_enables)   // R24
    else $error("data lines driven without select and enable");
  property p_power_fail_quiet;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.pf_q |=> (!data_lines_oe_o && !st_r.wr_act && deselected_o);
  endproperty
  a_power_fail_quiet: assert property (p_power_fail_quiet)         // R07
    else $error("bus active during power fail");
  property p_power_clears_ctrl;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.pf_q |=> (!st_r.ctrl[BIT_WRITE] && !st_r.ctrl[BIT_READ]);
  endproperty
  a_power_clears_ctrl: assert property (p_power_clears_ctrl)       // R20
    else $error("halt bits survive power fail");
  property p_frozen_copy;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (tick && halt && !wr_end) |=> $stable(st_r.vis);
  endproperty
  a_frozen_copy: assert property (p_frozen_copy)                   // R12
    else $error("visible copy refreshed while halted");
  property p_counts_on;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      (tick && !wr_end) |=> (st_r.cnt[T_SEC] != $past(st_r.cnt[T_SEC]));
  endproperty
  a_counts_on: assert property (p_counts_on)                       // R13
    else $error("counter did not advance on the second");
  property p_load_on_set_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      ($fell(st_r.ctrl[BIT_WRITE]) && !$past(st_r.pf_q))
        |-> (st_r.cnt == $past(st_r.vis) && st_r.tmr == '0);
  endproperty
  a_load_on_set_clear: assert property (p_load_on_set_clear)       // R18
    else $error("counters not loaded when set-time cleared");
  property p_recovery_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(st_r.pf_q) |-> deselected_o [*2];
  endproperty
  a_recovery_hold: assert property (p_recovery_hold)               // R25
    else $error("recovery deselect ended early");

endmodule : rtcw_ctrl

`default_nettype wire

// File: tb/rtcw_host.sv
/*
  Host model for the clock SRAM port: byte write and read cycles.
  Assumes core_clk_i from the bench; pins change at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcw_host
  import rtcw_pkg::*;
(
  // Clock
  input  wire logic              core_clk_i,
  // Device pins
  output logic      [ADDR_W-1:0] address_lines_o,
  output logic      [DATA_W-1:0] data_lines_o,
  output logic                   chip_sel_n_o,
  output logic                   out_en_n_o,
  output logic                   write_n_o,
  input  wire logic [DATA_W-1:0] data_lines_i,
  input  wire logic              data_lines_oe_i,
  // Status
  output logic                   timeout_o
);
  initial begin
    {address_lines_o, data_lines_o} = '0;
    {chip_sel_n_o, out_en_n_o, write_n_o} = 3'b111;
    timeout_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic pins(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic cs, input logic oe, input logic we);
    @(negedge core_clk_i);
    address_lines_o = a;
    data_lines_o = d;
    {chip_sel_n_o, out_en_n_o, write_n_o} = {cs, oe, we};
  endtask : pins

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    pins(a, d, 1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge core_clk_i);
    write_n_o = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chip_sel_n_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    data_lines_o = ~d;
  endtask : wr

  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (data_lines_oe_i !== lvl && n < 20) begin
      @(negedge core_clk_i);
      n++;
    end
    if (data_lines_oe_i !== lvl) timeout_o = 1'b1;
  endtask : wait_oe

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    pins(a, ~data_lines_o, 1'b0, 1'b0, 1'b1);
    wait_oe(1'b1);
    d = data_lines_i;
    chip_sel_n_o = 1'b1;
    out_en_n_o = 1'b1;
    wait_oe(1'b0);
  endtask : rd
endmodule : rtcw_host

`default_nettype wire

// File: tb/tb_rtcw_sram_write_and_update_control.sv
/*
  Bench for the clock SRAM port: table of byte accesses, then halt,
  set-time, pin sequencing and power-fail cases.
  Assumes short second and recovery counts set at the instance.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module tb_rtcw_sram_write_and_update_control;
  import rtcw_pkg::*;
  localparam int SEC_P = 20;
  localparam int REC_P = 8;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [7:0]        d;
    logic [7:0]        e;
  } rtcw_row_s;
  localparam rtcw_row_s ROWS [5] = '{
    '{17'h00000, 8'ha5, 8'ha5}, '{17'h1fff0, 8'h5a, 8'h5a},
    '{17'h1fff7, 8'h3c, 8'h3c}, '{17'h0ffff, 8'h81, 8'h81},
    '{ADDR_CTRL, 8'h3f, 8'h3f}};

  logic              core_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              power_fail = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        din;
  logic [7:0]        dout;
  logic              oe;
  logic              cs_n;
  logic              oe_n;
  logic              we_n;
  logic              desel;
  logic              tmo;
  logic [7:0]        v;
  logic [7:0]        s0;
  logic              bad;
  int                num_errors = 0;
  int                checks_done = 0;
  int                cyc = 0;
  int                n;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  rtcw_ctrl #(.SEC_CYCLES_P(SEC_P), .REC_CYCLES_P(REC_P)) DUT (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .address_lines_i(addr),
    .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_o(oe),
    .chip_sel_n_i(cs_n), .out_en_n_i(oe_n), .write_n_i(we_n),
    .power_fail_i(power_fail), .deselected_o(desel));

  rtcw_host host (
    .core_clk_i(core_clk), .address_lines_o(addr), .data_lines_o(din),
    .chip_sel_n_o(cs_n), .out_en_n_o(oe_n), .write_n_o(we_n),
    .data_lines_i(dout), .data_lines_oe_i(oe), .timeout_o(tmo));

  // Seconds value matches elapsed time within one step
  function automatic logic near(input logic [7:0] b);
    int d;
    d = b[7:4] * 10 + b[3:0] - (cyc - 6) / SEC_P;
    return (!$isunknown(b) && d >= -1 && d <= 1);
  endfunction : near

  task automatic complete_run;
    $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  always @(posedge tmo) begin
    num_errors++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    host.rd(ADDR_CTRL, v);
    `CHK("ctrl reset", CTRL_RESET, v)
    host.rd(17'h1fffc, v);
    `CHK("day reset", BCD_ONE, v)
    foreach (ROWS[i]) begin
      host.wr(ROWS[i].a, ROWS[i].d);
      host.rd(ROWS[i].a, v);
      `CHK("row data", ROWS[i].e, v)
    end
    host.wr(ADDR_CTRL, 8'h40);
    host.rd(ADDR_SEC, s0);
    `CHK("halt time", 1'b1, near(s0))
    repeat (60) @(negedge core_clk);
    host.rd(ADDR_SEC, v);
    `CHK("held sec", s0, v)
    host.wr(ADDR_CTRL, 8'h00);
    host.rd(ADDR_SEC, v);
    `CHK("no early refresh", s0, v)
    repeat (40) @(negedge core_clk);
    host.rd(ADDR_SEC, v);
    `CHK("count kept", 1'b1, near(v))
    // Set time near midnight
    host.wr(ADDR_CTRL, 8'h80);
    host.wr(ADDR_SEC, 8'h58);
    host.wr(17'h1fffa, BCD_59);
    host.wr(17'h1fffb, BCD_23);
    repeat (60) @(negedge core_clk);
    host.rd(ADDR_SEC, v);
    `CHK("set halt", 8'h58, v)
    host.wr(ADDR_CTRL, 8'h00);
    host.rd(ADDR_SEC, v);
    `CHK("set no early", 8'h58, v)
    repeat (10) @(negedge core_clk);
    host.rd(ADDR_SEC, v);
    `CHK("set loaded", BCD_59, v)
    repeat (10) @(negedge core_clk);
    host.rd(17'h1fffb, v);
    `CHK("hour wrap", BCD_ZERO, v)
    host.rd(17'h1fffc, v);
    `CHK("day carry", 8'h02, v)
    host.rd(17'h1fffa, v);
    `CHK("min wrap", BCD_ZERO, v)
    // Pin sequencing
    host.rd(17'h00100, v);
    host.pins(17'h00100, 8'h00, 1'b0, 1'b1, 1'b1);
    repeat (8) @(negedge core_clk);
    `CHK("oe without out_en", 1'b0, oe)
    host.pins(17'h00100, 8'h00, 1'b0, 1'b0, 1'b1);
    host.wait_oe(1'b1);
    host.pins(17'h00100, 8'h00, 1'b0, 1'b0, 1'b0);
    host.wait_oe(1'b0);
    `CHK("strobe float", 1'b0, oe)
    host.pins(17'h00100, 8'h00, 1'b1, 1'b0, 1'b1);
    repeat (6) @(negedge core_clk);
    host.pins(17'h00100, 8'h00, 1'b0, 1'b0, 1'b0);
    bad = 1'b0;
    repeat (10) begin
      @(negedge core_clk);
      if (oe !== 1'b0) bad = 1'b1;
    end
    `CHK("joint fall", 1'b0, bad)
    host.pins(17'h00100, 8'h00, 1'b1, 1'b1, 1'b1);
    // Power fail in mid-write
    host.wr(ADDR_CTRL, 8'h40);
    host.pins(17'h1fff0, 8'h77, 1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge core_clk);
    power_fail = 1'b1;
    repeat (8) @(negedge core_clk);
    `CHK("pf deselect", 1'b1, desel)
    host.pins(17'h1fff0, 8'h77, 1'b1, 1'b1, 1'b1);
    host.wr(17'h00000, 8'h11);
    host.pins(17'h00000, 8'h00, 1'b0, 1'b0, 1'b1);
    repeat (8) @(negedge core_clk);
    `CHK("pf float", 1'b0, oe)
    host.pins(17'h00000, 8'h00, 1'b1, 1'b1, 1'b1);
    power_fail = 1'b0;
    n = 0;
    while (desel === 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("recovery", 1'b1, n >= REC_P && n <= REC_P + 6)
    host.rd(17'h00000, v);
    `CHK("blocked write", 8'ha5, v)
    host.rd(17'h1fff7, v);
    `CHK("other byte kept", 8'h3c, v)
    host.rd(ADDR_CTRL, v);
    `CHK("ctrl after pf", 8'h00, v)
    complete_run();
  end
endmodule : tb_rtcw_sram_write_and_update_control

`default_nettype wire
